// ### fpe_pkg.sv
package fpe_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  // cycles in one millisecond, derived from the clock rate
  localparam int MS_CYC = CLK_HZ / MS_PER_S;

  // emission timing in milliseconds, plus burst length and pulse cap in pulses
  localparam int SEC_MS = 1000;
  localparam int PULSE_HIGH_MS = 2;
  localparam int PULSE_LOW_MS = 2;
  localparam int BURST_PAUSE_MS = 30;
  localparam int BURST_LEN = 10;
  localparam int MAX_PULSES = 125;

  // measurement schedule and averaging
  localparam int MEAS_MS = 1000;
  localparam int TEST_DIV_SHIFT = 2;
  localparam int AVG_LEN = 8;
  localparam int AVG_SHIFT = 3;

  // flow in ml/s times meter factor in milli-pulses per litre
  localparam int FLOW_W = 24;
  localparam int ACC_W = 40;
  localparam logic [ACC_W-1:0] PULSE_UNIT = 40'h00000f4240;
  localparam int MF_DEFAULT = 600;
  localparam int CUTOFF_DEFAULT = 10;

  typedef struct packed {
    logic valid;
    logic signed [FLOW_W-1:0] rate;
  } fpe_sample_t;

  typedef enum logic [1:0] {
    EM_IDLE = 2'b00,
    EM_HIGH = 2'b01,
    EM_LOW = 2'b10,
    EM_PAUSE = 2'b11
  } fpe_em_t;
endpackage

// ### fpe_top.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - each second compute pulses owed and emit them from the following second tick onward
// - pulses grouped in bursts, each pulse high two milliseconds
// - about thirty milliseconds pause between bursts
// - no pulses for flow below cut-off or negative flow
// - owed count clamps at 125 per second
// - pulse count linear in flow between cut-off and saturation
// - meter factor in milli-pulses per litre scales volume to pulses
// - pulse count uses average of last eight flow measurements
// - output held off until the averaging window has filled after power-up
// - measurements requested at fixed intervals
// - test mode changes only the measurement rate
// - volume integrated from flow each second, pulses taken from volume
// - test mode measurement interval is one quarter of normal
module fpe_top #(
  parameter int MS_CYCLES = fpe_pkg::MS_CYC,
  parameter int MF_MILLI = fpe_pkg::MF_DEFAULT,
  parameter int CUTOFF_ML = fpe_pkg::CUTOFF_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic test_pin_n,
  input wire fpe_pkg::fpe_sample_t sample,
  output logic meas_req,
  output logic test_mode,
  output logic pulse_out
);

  ////////////////////////////////////////////////////////////////////////////
  // millisecond and second ticks
  logic [31:0] ms_cnt;
  logic [15:0] sec_cnt;
  wire ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
  wire sec_tick = ms_tick && (sec_cnt == 16'(fpe_pkg::SEC_MS - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= '0;
      sec_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 32'h1;
      if (ms_tick) begin
        sec_cnt <= sec_tick ? '0 : sec_cnt + 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test strap, caught once at the first millisecond after reset
  logic pin_s1, pin_s2, strap_done;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      strap_done <= 1'b0;
      test_mode <= 1'b0;
    end else begin
      pin_s1 <= ~test_pin_n;
      pin_s2 <= pin_s1;
      if (ms_tick && !strap_done) begin
        strap_done <= 1'b1;
        test_mode <= pin_s2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement schedule
  // quarter interval
  wire [15:0] meas_period = test_mode ?
    16'(fpe_pkg::MEAS_MS >> fpe_pkg::TEST_DIV_SHIFT) : 16'(fpe_pkg::MEAS_MS);
  logic [15:0] meas_cnt;
  wire meas_due = ms_tick && (meas_cnt >= meas_period - 16'h1);
  // only the rate differs between modes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_cnt <= '0;
      meas_req <= 1'b0;
    end else begin
      meas_req <= meas_due;
      if (ms_tick) begin
        meas_cnt <= meas_due ? '0 : meas_cnt + 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // moving average over the last samples
  // sum width leaves headroom for eight full-scale samples
  localparam int SUM_W = fpe_pkg::FLOW_W + fpe_pkg::AVG_SHIFT;
  logic signed [fpe_pkg::FLOW_W-1:0] win [fpe_pkg::AVG_LEN];
  logic [fpe_pkg::AVG_SHIFT-1:0] wr_ptr;
  logic [fpe_pkg::AVG_SHIFT:0] fill;
  logic signed [fpe_pkg::FLOW_W+fpe_pkg::AVG_SHIFT-1:0] win_sum;
  wire signed [SUM_W-1:0] old_ext = SUM_W'(win[wr_ptr]);
  wire signed [SUM_W-1:0] new_ext = SUM_W'(sample.rate);
  wire signed [fpe_pkg::FLOW_W+fpe_pkg::AVG_SHIFT-1:0] avg_wide =
    win_sum >>> fpe_pkg::AVG_SHIFT;
  wire signed [fpe_pkg::FLOW_W-1:0] avg_flow = avg_wide[fpe_pkg::FLOW_W-1:0];
  // ready once the window holds real samples
  wire window_full = (fill == (fpe_pkg::AVG_SHIFT+1)'(fpe_pkg::AVG_LEN));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      fill <= '0;
      win_sum <= '0;
    end else if (sample.valid) begin
      wr_ptr <= wr_ptr + 1'b1;
      win_sum <= win_sum + new_ext - old_ext;
      if (!window_full) begin
        fill <= fill + 1'b1;
      end
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < fpe_pkg::AVG_LEN; gi++) begin : g_win
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          win[gi] <= '0;
        end else if (sample.valid && wr_ptr == fpe_pkg::AVG_SHIFT'(gi)) begin
          win[gi] <= sample.rate;
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // volume integration and pulse count
  // blank below cut-off and for reverse flow
  wire flow_ok = window_full && (avg_flow >= fpe_pkg::FLOW_W'(CUTOFF_ML));
  // meter factor scaling; linear in flow
  wire [fpe_pkg::ACC_W-1:0] vol_inc = fpe_pkg::ACC_W'(avg_flow) *
    fpe_pkg::ACC_W'(MF_MILLI);
  logic [fpe_pkg::ACC_W-1:0] acc;
  logic [7:0] owed;
  logic calc_busy;
  wire owed_full = (owed == 8'(fpe_pkg::MAX_PULSES));
  wire acc_whole = (acc >= fpe_pkg::PULSE_UNIT);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      owed <= '0;
      calc_busy <= 1'b0;
    end else if (sec_tick) begin
      owed <= '0;
      calc_busy <= 1'b1;
      // integrate flow over the second; residue kept while flow_ok, cleared when it is low
      acc <= flow_ok ? acc + vol_inc : '0;
    end else if (calc_busy) begin
      if (owed_full) begin
        acc <= '0;
        calc_busy <= 1'b0;
      end else if (acc_whole) begin
        acc <= acc - fpe_pkg::PULSE_UNIT;
        owed <= owed + 8'h1;
      end else begin
        calc_busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst emitter
  fpe_pkg::fpe_em_t em_state, next_state;
  logic [7:0] left;
  logic [7:0] in_burst;
  logic [7:0] ph;
  wire [7:0] ph_end = (em_state == fpe_pkg::EM_HIGH) ? 8'(fpe_pkg::PULSE_HIGH_MS - 1) :
    (em_state == fpe_pkg::EM_LOW) ? 8'(fpe_pkg::PULSE_LOW_MS - 1) :
    8'(fpe_pkg::BURST_PAUSE_MS - 1);
  wire ph_done = ms_tick && (ph == ph_end);
  wire last_pulse = (left == 8'h1);
  wire burst_end = (in_burst == 8'(fpe_pkg::BURST_LEN - 1));
  always_comb begin
    next_state = em_state;
    case (em_state)
      fpe_pkg::EM_IDLE: begin
        // owed count started on the second boundary
        if (sec_tick && owed != 8'h0) begin
          next_state = fpe_pkg::EM_HIGH;
        end
      end
      fpe_pkg::EM_HIGH: begin
        // pulse then gap, or a pause once a burst is complete
        if (ph_done) begin
          if (last_pulse) begin
            next_state = fpe_pkg::EM_IDLE;
          end else if (burst_end) begin
            next_state = fpe_pkg::EM_PAUSE;
          end else begin
            next_state = fpe_pkg::EM_LOW;
          end
        end
      end
      fpe_pkg::EM_LOW: begin
        if (ph_done) begin
          next_state = fpe_pkg::EM_HIGH;
        end
      end
      fpe_pkg::EM_PAUSE: begin
        if (ph_done) begin
          next_state = fpe_pkg::EM_HIGH;
        end
      end
      default: next_state = fpe_pkg::EM_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      em_state <= fpe_pkg::EM_IDLE;
      left <= '0;
      in_burst <= '0;
      ph <= '0;
      pulse_out <= 1'b0;
    end else begin
      em_state <= next_state;
      pulse_out <= (next_state == fpe_pkg::EM_HIGH);
      if (next_state != em_state) begin
        ph <= '0;
      end else if (ms_tick) begin
        ph <= ph + 8'h1;
      end
      if (em_state == fpe_pkg::EM_IDLE && next_state == fpe_pkg::EM_HIGH) begin
        left <= owed;
        in_burst <= '0;
      end else if (em_state == fpe_pkg::EM_HIGH && ph_done) begin
        left <= left - 8'h1;
        in_burst <= burst_end ? '0 : in_burst + 8'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  int hi_len, pause_len, meas_gap;
  logic meas_seen;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_len <= 0;
      pause_len <= 0;
      meas_gap <= 0;
      meas_seen <= 1'b0;
    end else begin
      hi_len <= pulse_out ? hi_len + 1 : 0;
      pause_len <= (em_state == fpe_pkg::EM_PAUSE) ? pause_len + 1 : 0;
      meas_gap <= meas_req ? 1 : meas_gap + 1;
      meas_seen <= meas_seen | meas_req;
    end
  end

  a_pulse_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(pulse_out) |-> hi_len == fpe_pkg::PULSE_HIGH_MS * MS_CYCLES)
    else $error("pulse high time wrong");
  a_burst_pause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (em_state == fpe_pkg::EM_PAUSE && next_state == fpe_pkg::EM_HIGH)
    |-> pause_len == fpe_pkg::BURST_PAUSE_MS * MS_CYCLES - 1)
    else $error("burst pause length wrong");
  a_cutoff_blank: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sec_tick && !flow_ok) |=> acc == '0 && owed == 8'h0)
    else $error("pulses owed below cut-off");
  a_rate_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    owed <= 8'(fpe_pkg::MAX_PULSES) && left <= 8'(fpe_pkg::MAX_PULSES))
    else $error("pulse count above maximum");
  a_second_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sec_tick |-> em_state == fpe_pkg::EM_IDLE && !calc_busy)
    else $error("emission overran the second");
  a_vol_integrate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sec_tick && flow_ok) |=> acc == $past(acc) + $past(vol_inc) && calc_busy)
    else $error("volume not integrated");
  a_residue_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(calc_busy) && !$past(owed_full) |-> acc < fpe_pkg::PULSE_UNIT && acc == $past(acc))
    else $error("remainder not carried");
  // nothing may be owed or emitted until eight real samples are averaged
  a_startup_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !window_full |-> owed == 8'h0 && !pulse_out)
    else $error("output enabled before window filled");
  a_meas_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (meas_req && meas_seen && strap_done && $stable(test_mode))
    |-> meas_gap == 32'(meas_period) * MS_CYCLES)
    else $error("measurement interval wrong");
  a_pulse_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (em_state == fpe_pkg::EM_IDLE && next_state == fpe_pkg::EM_HIGH)
    |=> left == $past(owed))
    else $error("emitter not loaded with owed count");
  c_burst_pause: cover property (@(posedge sys_clk) disable iff (!rst_n)
    em_state == fpe_pkg::EM_PAUSE);
  c_saturated: cover property (@(posedge sys_clk) disable iff (!rst_n)
    calc_busy && owed_full);
  c_test_mode: cover property (@(posedge sys_clk) disable iff (!rst_n)
    test_mode && meas_req);
  c_emit_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(pulse_out) && em_state == fpe_pkg::EM_IDLE);
endmodule
`default_nettype wire

// ### fpe_calc_model.sv
`timescale 1ns/10ps
`default_nettype none
// far-side counter: counts volume pulses, burst pauses and timing faults
module fpe_calc_model #(
  parameter int MS_CYCLES = 10
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pulse_out,
  output int pulses,
  output int bursts,
  output int bad
);
  logic prev;
  int hi;
  int lo;

  ////////////////////////////////////////////////////////////////////////////////
  // tolerates a silent output after power-up, demands nothing of it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
      hi <= 0;
      lo <= 0;
      pulses <= 0;
      bursts <= 0;
      bad <= 0;
    end else begin
      prev <= pulse_out;
      if (pulse_out && !prev) begin
        pulses <= pulses + 1;
        hi <= 1;
        // long gaps open a new frame, so only short ones are judged
        if (pulses > 0 && lo <= 40 * MS_CYCLES) begin
          if (lo >= 29 * MS_CYCLES && lo <= 33 * MS_CYCLES) begin
            bursts <= bursts + 1;
          end else if (lo != 2 * MS_CYCLES) begin
            bad <= bad + 1;
          end
        end
      end else if (pulse_out) begin
        hi <= hi + 1;
      end
      if (!pulse_out && prev) begin
        lo <= 1;
        if (hi < 2 * MS_CYCLES || hi > 5 * MS_CYCLES) begin
          bad <= bad + 1;
        end
      end else if (!pulse_out) begin
        lo <= lo + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### fpe_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0d got %0d", nm, ex, gt); end end
module fpe_top_tb;
  localparam int MS = 10;
  localparam int SEC = 1000 * MS;
  localparam int MF = 600;
  localparam int CUT = 10;
  logic sys_clk;
  logic rst_n;
  logic test_pin_n;
  fpe_pkg::fpe_sample_t sample;
  logic meas_req;
  logic test_mode;
  logic pulse_out;
  int pulses;
  int bursts;
  int bad;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 32'ha9287608;
  int cyc;
  int mgap;
  bit mseen;
  bit tmode;
  int win[$];
  longint acc;
  int exp_n;
  int nxt_n;
  int last_p;
  int last_b;

  fpe_top #(.MS_CYCLES(MS), .MF_MILLI(MF), .CUTOFF_ML(CUT)) u_fpe_top (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .test_pin_n(test_pin_n),
    .sample(sample),
    .meas_req(meas_req),
    .test_mode(test_mode),
    .pulse_out(pulse_out)
  );

  fpe_calc_model #(.MS_CYCLES(MS)) u_fpe_calc_model (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pulse_out(pulse_out),
    .pulses(pulses),
    .bursts(bursts),
    .bad(bad)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end

  // sampled mid-cycle, away from the edge that launches the request
  always @(negedge sys_clk) begin
    if (!rst_n) begin
      mseen = 1'b0;
      mgap = 0;
    end else begin
      mgap++;
      if (meas_req) begin
        if (mseen) `CHK("meas gap", (tmode ? 250 : 1000) * MS, mgap)
        mseen = 1'b1;
        mgap = 0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference: window average, volume accumulation, cap and remainder
  function automatic int calc();
    longint sum;
    int n;
    sum = 0;
    n = 0;
    foreach (win[i]) sum += win[i];
    if (win.size() == 8 && (sum >>> 3) >= CUT) begin
      acc += (sum >>> 3) * MF;
      n = int'(acc / 1000000);
      if (n >= 125) begin
        n = 125;
        acc = 0;
      end else begin
        acc -= longint'(n) * 1000000;
      end
    end else begin
      acc = 0;
    end
    return n;
  endfunction

  task automatic feed(int md);
    int k;
    int r;
    k = (md == 3) ? 8 : {$random(seed)} % 9;
    repeat (k) begin
      r = {$random(seed)} % 200000;
      case (md)
        0: r = -1 - r % 5000;
        1: r = r % CUT;
        2: r = CUT + r % 150000;
        default: r = 200000 + r;
      endcase
      @(negedge sys_clk) sample = '{1'b1, r[23:0]};
      win.push_back(r);
      if (win.size() > 8) win.pop_front();
      @(negedge sys_clk) sample.valid = 1'b0;
    end
  endtask

  task automatic do_reset(bit tm);
    @(negedge sys_clk) rst_n = 1'b0;
    test_pin_n = !tm;
    tmode = tm;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    win.delete();
    acc = 0;
    exp_n = 0;
    nxt_n = 0;
    last_p = 0;
    last_b = 0;
  endtask

  // samples go in late in each second so the next tick sees them all
  task automatic run_secs(int n);
    for (int s = 0; s < n; s++) begin
      while (cyc < s * SEC + 950 * MS) @(negedge sys_clk);
      `CHK("pulses", exp_n, pulses - last_p)
      `CHK("bursts", (exp_n > 0) ? (exp_n - 1) / 10 : 0, bursts - last_b)
      `CHK("timing faults", 0, bad)
      `CHK("mode", tmode, test_mode)
      last_p = pulses;
      last_b = bursts;
      // a second's samples are counted at the next tick and emitted from the one after
      exp_n = nxt_n;
      while (cyc < s * SEC + 960 * MS) @(negedge sys_clk);
      feed(s % 4);
      nxt_n = calc();
    end
  endtask

  task automatic end_of_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (120000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    test_pin_n = 1'b1;
    sample = '0;
    tmode = 1'b0;
    do_reset(1'b0);
    run_secs(6);
    // second reset with the strap pulled low selects the fast schedule
    do_reset(1'b1);
    run_secs(3);
    end_of_test();
  end
endmodule
`default_nettype wire
